// ===== core/flash_protect_addr_extend.sv
// Write-protection decode and upper address extension for a 32 MB serial flash
`timescale 1ns/1ns

// Summary of operation
// - Range scheme, no complement: value n of 1 to 9 protects 2^(n-1) blocks, top or bottom; 10 and up protect all.
// - Complement set protects exactly the blocks left free otherwise.
// - Erase or program touching any protected part is ignored entirely.
// - Lock bits apply only with scheme select at one, else range decode.
// - All block and sector lock bits come up set to one.
// - Extension byte supplies top address byte only in 3-byte mode.
// - 3-byte mode with upper half select zero addresses the lower half.
// - 3-byte mode with upper half select one addresses the upper half.
// - 4-byte mode ignores the extension; host then sends four address bytes.
// - Any 4-byte addressed command overwrites the extension byte.
// - Power-up and reset clear the extension byte.
// - Scheme select chooses range bits at zero, block locks at one.
// - Power-up mode bit one starts in 4-byte mode, zero in 3-byte mode.
// - Host reads extension with C8h and writes it with C5h, one byte.
module flash_protect_addr_extend (
  input  wire logic                              ref_clk,
  input  wire logic                              reset_n,
  input  wire flash_protect_pkg::protect_cfg_type protectCfg,
  input  wire logic                              power_up_address_mode,
  input  wire logic                              enter4ByteMode,
  input  wire logic                              exit4ByteMode,
  input  wire logic                              extensionWrite,
  input  wire logic [7:0]                        extensionWriteData,
  input  wire logic                              lockWrite,
  input  wire logic                              lockValue,
  input  wire logic                              lockAll,
  input  wire logic [flash_protect_pkg::ADDR_BITS-1:0] lockAddress,
  input  wire flash_protect_pkg::access_req_type accessReq,
  output flash_protect_pkg::access_resp_type     accessResp,
  output logic                                   current_address_mode,
  output logic [7:0]                             extension_address_byte
);

  localparam int unsigned AW = flash_protect_pkg::ADDR_BITS;
  localparam int unsigned BW = flash_protect_pkg::BLOCK_BITS;

  // Lock index of an address: per-sector bits for first and last block, else per block
  function automatic logic [9:0] lock_index(input logic [AW-1:0] a);
    logic [BW-1:0] blk;
    blk = a[AW-1:flash_protect_pkg::BLOCK_LSB];
    if (blk == '0)
      lock_index = {6'h00, a[15:12]};
    else if (blk == '1)
      lock_index = {6'h00, 4'h0} + 10'(16) + {6'h00, a[15:12]};
    else
      lock_index = 10'(32) + {1'b0, blk};
    lock_index = lock_index;
  endfunction

  // Range-protection test of one block number
  function automatic logic range_hit(input flash_protect_pkg::protect_cfg_type c,
                                     input logic [BW-1:0] blk);
    logic       inRange;
    logic [3:0] n;
    logic [BW-1:0] size;
    inRange = 1'b0;
    n = c.block_protect;
    size = '0;
    if (n[3] && (n[2] || n[1])) begin
      inRange = 1'b1;
    end else if (n != 4'h0) begin
      size = BW'(1) << (n - 4'h1);
      if (c.top_bottom_select)
        inRange = blk < size;
      else
        inRange = blk >= BW'(10'd512 - {1'b0, size});
    end
    range_hit = c.complement_protect ? !inRange : inRange;
  endfunction

  // Lock bits: 16 sectors of block 0, 16 of block 511, then blocks 1..510 at 33..
  logic [543:0] lockBits;
  logic [543:0] next_lockBits;
  logic         addressMode;
  logic         next_addressMode;
  logic         started;
  logic         next_started;
  logic [7:0]   extension;
  logic [7:0]   next_extension;
  flash_protect_pkg::access_resp_type next_accessResp;

  // Address, range and check state for the request
  logic [AW-1:0] firstAddr;
  logic [AW-1:0] lastAddr;
  logic [AW:0]   lastWide;
  logic          blocked;

  // Address mode: power-up mode bit on the first clock, then enter and exit pulses
  // A request on that first clock still sees the reset mode, so the host waits one clock
  always_comb begin
    next_started     = 1'b1;
    next_addressMode = addressMode;
    if (!started) begin
      next_addressMode = power_up_address_mode;
    end else if (enter4ByteMode) begin
      next_addressMode = 1'b1;
    end else if (exit4ByteMode) begin
      next_addressMode = 1'b0;
    end
  end

  // Mode registers; the status output mirrors the internal bit
  // Both load the same next value, so they never disagree
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addressMode          <= 1'b0;
      started              <= 1'b0;
      current_address_mode <= 1'b0;
    end else begin
      addressMode          <= next_addressMode;
      started              <= next_started;
      current_address_mode <= next_addressMode;
    end
  end

  // Extension byte: host write first, then a 4-byte request overwrites it
  // When both meet in one cycle the request wins, as its address is the newer one
  always_comb begin
    next_extension = extension;
    if (extensionWrite) begin
      next_extension = extensionWriteData;
    end
    if (accessReq.valid && addressMode) begin
      next_extension = accessReq.upperByte;
    end
  end

  // Extension registers, cleared on reset
  // The output copy is the read answer for the host
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      extension              <= flash_protect_pkg::EXTENSION_RESET;
      extension_address_byte <= flash_protect_pkg::EXTENSION_RESET;
    end else begin
      extension              <= next_extension;
      extension_address_byte <= next_extension;
    end
  end

  // Effective address: bit 0 of the extension picks the half in 3-byte mode
  // Upper extension bits reach no storage on this array size
  always_comb begin
    if (addressMode) begin
      firstAddr = {accessReq.upperByte[0], accessReq.lowAddress};
    end else begin
      firstAddr = {extension[0], accessReq.lowAddress};
    end
    // A region running past the top of the array stops at the last byte
    lastWide = {1'b0, firstAddr} + {1'b0, accessReq.span};
    lastAddr = lastWide[AW] ? '1 : lastWide[AW-1:0];
  end

  // Walk every 4 KB sector that the region covers; one protected sector blocks it all
  // The walk is wide but purely combinational, so the answer still takes one clock
  // The range scheme needs only the block number, the lock scheme the sector index
  always_comb begin
    blocked = 1'b0;
    for (int s = 0; s < 8192; s++) begin
      logic [AW-1:0] probe;
      probe = AW'(s) << flash_protect_pkg::SECTOR_LSB;
      if (probe[AW-1:12] >= firstAddr[AW-1:12] && probe[AW-1:12] <= lastAddr[AW-1:12]) begin
        if (protectCfg.protection_scheme_select) begin
          blocked = blocked | lockBits[lock_index(probe)];
        end else begin
          blocked = blocked | range_hit(protectCfg, probe[AW-1:16]);
        end
      end
    end
  end

  // Verdict: a one-cycle answer for every request
  // A refused request is still answered, with accepted low, and the command is dropped
  always_comb begin
    next_accessResp = '0;
    if (accessReq.valid) begin
      next_accessResp.valid    = 1'b1;
      next_accessResp.accepted = !blocked;
      next_accessResp.address  = firstAddr;
    end
  end

  // Verdict register; the answer stands for one cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      accessResp <= '0;
    end else begin
      accessResp <= next_accessResp;
    end
  end

  // Lock updates from the host side; a global update wins over a single one
  // Sectors of the first and last block have their own bits, other blocks share one
  always_comb begin
    next_lockBits = lockBits;
    if (lockAll) begin
      next_lockBits = {544{lockValue}};
    end else if (lockWrite) begin
      next_lockBits[lock_index(lockAddress)] = lockValue;
    end
  end

  // Lock registers all come up set, so the array starts protected
  // A user must clear them before the lock scheme lets anything through
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lockBits <= {544{flash_protect_pkg::LOCK_RESET}};
    end else begin
      lockBits <= next_lockBits;
    end
  end

endmodule // flash_protect_addr_extend

// ===== core/flash_protect_pkg.sv
// Package with constants and carrier types for the flash protection block
package flash_protect_pkg;

  // Array geometry: 512 blocks of 64 KB, 16 sectors of 4 KB per block
  localparam int unsigned BLOCK_BITS   = 9;
  localparam int unsigned ADDR_BITS    = 25;
  localparam int unsigned BLOCK_LSB    = 16;
  localparam int unsigned SECTOR_LSB   = 12;
  localparam int unsigned LOCK_COUNT   = 512;
  localparam int unsigned SECTOR_COUNT = 32;

  // Reset values and command opcodes
  localparam logic [7:0] EXTENSION_RESET = 8'h00;
  localparam logic       LOCK_RESET      = 1'b1;
  localparam logic [7:0] OPCODE_READ_EXT  = 8'hC8;
  localparam logic [7:0] OPCODE_WRITE_EXT = 8'hC5;
  localparam logic [7:0] OPCODE_ENTER_4B  = 8'hB7;

  // Range protection settings from the status bits
  typedef struct packed {
    logic       protection_scheme_select;
    logic       complement_protect;
    logic       top_bottom_select;
    logic [3:0] block_protect;
  } protect_cfg_type;

  // One erase or program request: covered region as first byte address and span to the last byte
  typedef struct packed {
    logic                 valid;
    logic                 fourByte;
    logic [7:0]           upperByte;
    logic [23:0]          lowAddress;
    logic [ADDR_BITS-1:0] span;
  } access_req_type;

  // Verdict on a request
  typedef struct packed {
    logic                 valid;
    logic                 accepted;
    logic [ADDR_BITS-1:0] address;
  } access_resp_type;

endpackage

// ===== test/flash_host_model.sv
// Host controller model issuing access, mode and extension commands
`timescale 1ns/1ns
module flash_host_model (
  input  wire logic                           ref_clk,
  output flash_protect_pkg::access_req_type   req,
  output logic                                extWr,
  output logic [7:0]                          extData,
  output logic                                enter,
  output logic                                leave
);
  initial {req, extWr, extData, enter, leave} = '0;
  // One command a cycle: 0 access, 1 enter, 2 leave, 3 write extension, else idle
  task automatic op(input int k, input logic [63:0] r);
    @(posedge ref_clk);
    #1;
    {req, extWr, enter, leave} = '0;
    extData = r[7:0];
    case (k)
      0: req = {1'b1, 1'b1, r[7:0], r[31:8], 7'h00, r[49:32]};
      1: enter = 1'b1;
      2: leave = 1'b1;
      3: extWr = 1'b1;
      default: ;
    endcase
  endtask
endmodule // flash_host_model

// ===== test/flash_protect_properties.sv
// Checker for the flash protection and address extension block
`timescale 1ns/1ns
module flash_protect_properties (
  input wire logic                               ref_clk,
  input wire logic                               reset_n,
  input wire flash_protect_pkg::protect_cfg_type  protectCfg,
  input wire logic                               enter4ByteMode,
  input wire flash_protect_pkg::access_req_type   accessReq,
  input wire flash_protect_pkg::access_resp_type  accessResp,
  input wire logic                               current_address_mode,
  input wire logic [7:0]                         extension_address_byte
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Requests under each address mode and under the range scheme
  sequence s_req3; accessReq.valid && !current_address_mode; endsequence
  sequence s_req4; accessReq.valid && current_address_mode; endsequence
  sequence s_range; accessReq.valid && !protectCfg.protection_scheme_select; endsequence
  chk_resp_timing: assert property (accessReq.valid |=> accessResp.valid)
    else $error("answer missing");
  chk_no_spurious: assert property (!accessReq.valid |=> !accessResp.valid)
    else $error("answer without request");
  chk_ext_half: assert property (s_req3 |=>
    accessResp.address[24] == $past(extension_address_byte[0])) else $error("half wrong");
  chk_four_byte: assert property (s_req4 |=> accessResp.address[24] == $past(accessReq.upperByte[0])
    && extension_address_byte == $past(accessReq.upperByte)) else $error("4-byte wrong");
  chk_low_addr: assert property (accessReq.valid |=>
    accessResp.address[23:0] == $past(accessReq.lowAddress)) else $error("low address");
  chk_all_range: assert property (s_range ##0 protectCfg.block_protect[3] &&
    |protectCfg.block_protect[2:1] |=> accessResp.accepted == $past(protectCfg.complement_protect))
    else $error("whole-array verdict");
  chk_bp_zero: assert property (s_range ##0 protectCfg.block_protect == 4'h0 |=>
    accessResp.accepted != $past(protectCfg.complement_protect)) else $error("zero verdict");
  chk_ext_reset: assert property ($rose(reset_n) |-> extension_address_byte == 8'h00)
    else $error("extension not cleared");
  chk_mode_enter: assert property (enter4ByteMode |=> current_address_mode)
    else $error("mode not entered");
endmodule // flash_protect_properties
bind flash_protect_addr_extend flash_protect_properties chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .protectCfg(protectCfg), .enter4ByteMode(enter4ByteMode), .accessReq(accessReq),
  .accessResp(accessResp), .current_address_mode(current_address_mode),
  .extension_address_byte(extension_address_byte));

// ===== test/tb.sv
// Self-checking bench for the flash protection and address extension block
`timescale 1ns/1ns
module tb;
  logic ref_clk = 0, reset_n = 0, pwrMode = 0, lockAll = 0, enter, leave, extWr, mode;
  flash_protect_pkg::protect_cfg_type  cfg = 7'h40;
  flash_protect_pkg::access_req_type   req;
  flash_protect_pkg::access_resp_type  resp;
  logic [7:0]  extData, ext;
  logic [25:0] expQ[$];
  logic [63:0] r = '0;
  int n_mismatch = 0, checks_done = 0, cyc = 0, seed = 32'h6d0f, k, mMode = 0, mExt = 0, locked = 1;
  always #20 ref_clk = ~ref_clk;
  flash_host_model host (.ref_clk(ref_clk), .req(req), .extWr(extWr), .extData(extData),
    .enter(enter), .leave(leave));
  flash_protect_addr_extend dut (.ref_clk(ref_clk), .reset_n(reset_n), .protectCfg(cfg),
    .power_up_address_mode(pwrMode), .enter4ByteMode(enter), .exit4ByteMode(leave),
    .extensionWrite(extWr), .extensionWriteData(extData), .lockWrite(1'b0), .lockValue(1'b0),
    .lockAll(lockAll), .lockAddress(25'h000_0000), .accessReq(req), .accessResp(resp),
    .current_address_mode(mode), .extension_address_byte(ext));
  task automatic fail(input string m);
    $display("unexpected at %0t: %s", $time, m);
    n_mismatch++;
  endtask
  task automatic wrap_up();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Range-scheme protection of one 64 KB block
  function automatic bit blockProt(int b);
    int bp = int'(cfg.block_protect);
    int n = (bp == 0) ? 0 : 1 << (bp - 1);
    return (bp >= 10 || (bp != 0 && (cfg.top_bottom_select ? b < n : b >= 512 - n)))
      ^ cfg.complement_protect;
  endfunction
  // Reference model: effective address, verdict, mode and extension
  task automatic model(input int k);
    int a, last, ok;
    if (k == 1) mMode = 1;
    if (k == 2) mMode = 0;
    if (k == 3) mExt = int'(r[7:0]);
    if (k != 0) return;
    a = int'(r[31:8]) + ((mMode != 0 ? int'(r[0]) : mExt % 2) << 24);
    if (mMode != 0) mExt = int'(r[7:0]);
    last = a + int'(r[49:32]);
    if (last > 32'h01ff_ffff) last = 32'h01ff_ffff;
    ok = 1;
    for (int b = a >> 16; b <= last >> 16; b++)
      if (cfg.protection_scheme_select ? locked != 0 : blockProt(b)) ok = 0;
    expQ.push_back({ok[0], a[24:0]});
  endtask
  // Compare each answer with the model
  always @(negedge ref_clk) if (resp.valid === 1'b1) begin
    checks_done++;
    if (expQ.size() == 0) fail("spurious answer");
    else if (resp !== {1'b1, expQ.pop_front()}) fail("verdict or address");
  end
  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 reset_n = 1;
    host.op(0, r);
    model(0);
    host.op(4, r);
    lockAll = 1;
    host.op(0, r);
    lockAll = 0;
    locked = 0;
    model(0);
    repeat (2) begin
      for (int i = 0; i < 300; i++) begin
        r = {$random(seed), $random(seed)};
        k = r[63] ? 0 : int'(r[62:61]);
        host.op(k, r);
        if (i % 16 == 0) cfg = {1'b0, r[58:53]};
        model(k);
      end
      host.op(4, r);
      @(posedge ref_clk);
      #1 reset_n = 0;
      pwrMode = 1;
      mMode = 1;
      mExt = 0;
      @(posedge ref_clk);
      #1 reset_n = 1;
      @(posedge ref_clk);
      #1 checks_done++;
      if (mode !== 1'b1 || ext !== 8'h00) fail("state after reset");
    end
    wrap_up();
  end
endmodule // tb
